// [verilog/tdec_pkg.sv]
// package for turbo decoder execution control register bank
`default_nettype none
package tdec_pkg;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_EXEC = 8'h00;
    localparam logic [7:0] OFS_END = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_IC0 = 8'h40;
    localparam logic [7:0] OFS_IC_LAST = 8'h7C;

    // execution instruction codes
    localparam logic [3:0] EXE_NONE = 4'h0;
    localparam logic [3:0] EXE_START = 4'h1;
    localparam logic [3:0] EXE_SOFT_RESET = 4'h2;
    localparam logic [3:0] EXE_DEBUG = 4'h4;
    localparam logic [3:0] EXE_STEP = 4'h5;
    localparam logic [3:0] EXE_COMPLETE = 4'h6;

    // endian/sleep register field positions
    localparam int END_EXT_BIT = 0;
    localparam int END_INTER_BIT = 1;
    localparam int END_SLP_VSS_BIT = 4;
    localparam int END_SLP_VDD_BIT = 5;
    localparam logic [5:0] END_RESET = 6'h00;

    // status register field positions
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_WAIT_IC_BIT = 1;
    localparam int STAT_DEBUG_BIT = 2;
    localparam int STAT_STATE_LSB = 4;

    // map decoder states; a debug step stops in state 6
    localparam logic [3:0] MAP_IDLE = 4'h0;
    localparam logic [3:0] MAP_FIRST = 4'h1;
    localparam logic [3:0] MAP_HOLD = 4'h6;
    localparam logic [3:0] MAP_LAST = 4'h8;

    localparam int IC_WORDS = 16;
    localparam int INIT_CYCLES = 4;
    localparam int MAP_CYCLES = 8;
    localparam int DEFAULT_DECODES = 4;

    typedef enum logic [2:0] {
        SQ_IDLE, SQ_INIT, SQ_DBG_WAIT, SQ_RUN, SQ_DBG_HOLD
    } tdec_seq_e;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } tdec_wreq_s;

endpackage : tdec_pkg
`default_nettype wire

// [verilog/tdec_icmem.sv]
// memory of the sixteen input configuration words
`timescale 1ns/100ps
`default_nettype none
module tdec_icmem #(
    parameter int WORDS = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    // read port, registered data
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem_q [WORDS];

    always_ff @(posedge clk) begin
        for (int i = 0; i < WORDS; i++) begin
            if (!rst_n || clear) begin
                mem_q[i] <= 32'h0000_0000;
            end else if (we && waddr == AW'(i)) begin
                mem_q[i] <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= mem_q[raddr];
        end
    end
endmodule : tdec_icmem
`default_nettype wire

// [verilog/tdec_seq.sv]
// map decoder sequencer with debug hold and step
`timescale 1ns/100ps
`default_nettype none
module tdec_seq #(
    parameter int DECODES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    // instruction strobes
    input wire logic go_start,
    input wire logic go_debug,
    input wire logic go_step,
    input wire logic go_complete,
    // state
    output logic [3:0] map_state,
    output logic in_debug,
    output logic wait_ic
);
    localparam int CW = 8;
    localparam logic [CW-1:0] INIT_N = CW'(tdec_pkg::INIT_CYCLES - 1);
    localparam logic [CW-1:0] MAP_N = CW'(tdec_pkg::MAP_CYCLES - 1);
    localparam logic [CW-1:0] DEC_N = CW'(DECODES - 1);

    tdec_pkg::tdec_seq_e seq_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] dec_q;
    logic dbg_q;
    logic step_q;
    logic [3:0] st_q;

    wire cnt_done = (cnt_q == MAP_N);
    wire last_dec = (dec_q == DEC_N);

    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            seq_q <= tdec_pkg::SQ_IDLE;
            cnt_q <= '0;
            dec_q <= '0;
            dbg_q <= 1'b0;
            step_q <= 1'b0;
            st_q <= tdec_pkg::MAP_IDLE;
        end else begin
            case (seq_q)
                tdec_pkg::SQ_IDLE: begin
                    cnt_q <= '0;
                    dec_q <= '0;
                    st_q <= tdec_pkg::MAP_IDLE;
                    if (go_start || go_debug) begin
                        seq_q <= tdec_pkg::SQ_INIT;
                        dbg_q <= go_debug;
                    end
                end
                tdec_pkg::SQ_INIT: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == INIT_N) begin
                        cnt_q <= '0;
                        st_q <= dbg_q ? tdec_pkg::MAP_IDLE
                                      : tdec_pkg::MAP_FIRST;
                        seq_q <= dbg_q ? tdec_pkg::SQ_DBG_WAIT
                                       : tdec_pkg::SQ_RUN;
                    end
                end
                tdec_pkg::SQ_DBG_WAIT: begin
                    st_q <= tdec_pkg::MAP_IDLE;
                    if (go_step || go_complete) begin
                        step_q <= go_step;
                        st_q <= tdec_pkg::MAP_FIRST;
                        seq_q <= tdec_pkg::SQ_RUN;
                    end
                end
                tdec_pkg::SQ_RUN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (st_q != tdec_pkg::MAP_LAST) begin
                        st_q <= st_q + 4'h1;
                    end
                    if (cnt_done) begin
                        cnt_q <= '0;
                        dec_q <= dec_q + 1'b1;
                        st_q <= tdec_pkg::MAP_FIRST;
                        if (last_dec) begin
                            seq_q <= tdec_pkg::SQ_IDLE;
                            st_q <= tdec_pkg::MAP_IDLE;
                            dbg_q <= 1'b0;
                        end else if (step_q) begin
                            seq_q <= tdec_pkg::SQ_DBG_HOLD;
                            st_q <= tdec_pkg::MAP_HOLD;
                        end
                    end
                end
                tdec_pkg::SQ_DBG_HOLD: begin
                    st_q <= tdec_pkg::MAP_HOLD;
                    if (go_step || go_complete) begin
                        step_q <= go_step;
                        st_q <= tdec_pkg::MAP_FIRST;
                        seq_q <= tdec_pkg::SQ_RUN;
                    end
                end
                default: begin
                    seq_q <= tdec_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    assign map_state = st_q;
    assign in_debug = dbg_q;
    // decoder waits for new words whenever it is idle
    assign wait_ic = (seq_q == tdec_pkg::SQ_IDLE);
endmodule : tdec_seq
`default_nettype wire

// [verilog/tdec_ctrl.sv]
// turbo decoder execution control register bank with AHB-Lite slave
// Contract
// - writing code 1h starts normal decoding
// - writing code 4h enters debug mode after normal initialisation
// - in debug mode the decoder holds in map state 0
// - code 5h in debug runs one map decode then holds in state 6
// - code 6h in debug runs all remaining decodes to the end
// - soft reset clears all but execution and endian/sleep registers
// - extrinsic format bit: 1 native 8-bit, 0 packed 32-bit, read/write
// - interleaver format bit, same encoding, read/write
// - one write can select native format for all data
// - vss sleep bit: 0 sleep disabled, 1 internal control enabled
// - vdd sleep bit: 0 sleep disabled, 1 internal control enabled
// - sixteen input configuration words are writable by the cpu
// - the input configuration words read back as programmed; a read right after a write to the same word returns the old word
// - run status tells idle state 0 from active states 1 to 8
// - wait flag shows decoder awaits new configuration words
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tdec_ctrl #(
    parameter int DECODES = tdec_pkg::DEFAULT_DECODES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // decoder side
    output logic EXT_NATIVE,
    output logic INTER_NATIVE,
    output logic SLEEP_VSS_EN,
    output logic SLEEP_VDD_EN,
    output logic [3:0] MAP_STATE,
    output logic RUN_STATUS,
    output logic WAIT_CONFIG_FLAG
);
    // address phase capture
    tdec_pkg::tdec_wreq_s req_q;
    logic rd_q;
    logic [3:0] execute_instruction_field_q;
    logic [5:0] endian_sleep_register_q;

    wire addr_ok = HSEL && HREADY && HTRANS[1];
    wire [7:0] a_lo = HADDR[7:0];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            req_q <= '0;
            rd_q <= 1'b0;
        end else begin
            req_q.wr <= addr_ok && HWRITE;
            rd_q <= addr_ok && !HWRITE;
            if (addr_ok) begin
                req_q.addr <= a_lo;
            end
        end
    end

    // data phase write decode
    wire wr_exec = req_q.wr && req_q.addr == tdec_pkg::OFS_EXEC;
    wire wr_end = req_q.wr && req_q.addr == tdec_pkg::OFS_END;
    wire in_ic_w = req_q.addr >= tdec_pkg::OFS_IC0
                && req_q.addr <= tdec_pkg::OFS_IC_LAST;
    wire wr_ic = req_q.wr && in_ic_w;
    wire [3:0] ic_widx = req_q.addr[5:2];
    wire [3:0] code = HWDATA[3:0];
    wire go_start = wr_exec && code == tdec_pkg::EXE_START;
    wire go_debug = wr_exec && code == tdec_pkg::EXE_DEBUG;
    wire go_step = wr_exec && code == tdec_pkg::EXE_STEP;
    wire go_complete = wr_exec && code == tdec_pkg::EXE_COMPLETE;
    wire soft_rst = wr_exec && code == tdec_pkg::EXE_SOFT_RESET;

    // execution and endian registers survive a soft reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            execute_instruction_field_q <= tdec_pkg::EXE_NONE;
            endian_sleep_register_q <= tdec_pkg::END_RESET;
        end else begin
            if (wr_exec) begin
                execute_instruction_field_q <= code;
            end
            if (wr_end) begin
                endian_sleep_register_q <= HWDATA[5:0];
            end
        end
    end

    // ic words: read index is taken in the address phase so the
    // registered memory output lines up with the data phase
    wire [3:0] ic_ridx = a_lo[5:2];
    logic [31:0] ic_rdata;

    tdec_icmem #(
        .WORDS(tdec_pkg::IC_WORDS),
        .AW(4)
    ) u_icmem (
        .clk(CLK),
        .rst_n(RST_N),
        .clear(soft_rst),
        .we(wr_ic),
        .waddr(ic_widx),
        .wdata(HWDATA),
        .raddr(ic_ridx),
        .rdata(ic_rdata)
    );

    logic [3:0] map_state;
    logic in_debug;
    logic wait_ic;

    tdec_seq #(
        .DECODES(DECODES)
    ) u_seq (
        .clk(CLK),
        .rst_n(RST_N),
        .soft_rst(soft_rst),
        .go_start(go_start),
        .go_debug(go_debug),
        .go_step(go_step && in_debug),
        .go_complete(go_complete && in_debug),
        .map_state(map_state),
        .in_debug(in_debug),
        .wait_ic(wait_ic)
    );

    wire run = map_state != tdec_pkg::MAP_IDLE;

    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[tdec_pkg::STAT_RUN_BIT] = run;
        stat_word[tdec_pkg::STAT_WAIT_IC_BIT] = wait_ic;
        stat_word[tdec_pkg::STAT_DEBUG_BIT] = in_debug;
        stat_word[tdec_pkg::STAT_STATE_LSB +: 4] = map_state;
    end

    // read mux in the data phase; unmapped reads return zero
    wire [31:0] exec_word = {28'h000_0000, execute_instruction_field_q};
    wire [31:0] end_word = {26'h0, endian_sleep_register_q};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_q) begin
            if (req_q.addr == tdec_pkg::OFS_EXEC) begin
                rd_mux = exec_word;
            end else if (req_q.addr == tdec_pkg::OFS_END) begin
                rd_mux = end_word;
            end else if (req_q.addr == tdec_pkg::OFS_STAT) begin
                rd_mux = stat_word;
            end else if (in_ic_w) begin
                rd_mux = ic_rdata;
            end
        end
    end

    assign HRDATA = rd_mux;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign EXT_NATIVE = endian_sleep_register_q[tdec_pkg::END_EXT_BIT];
    assign INTER_NATIVE = endian_sleep_register_q[tdec_pkg::END_INTER_BIT];
    // sleep enables gated while running: only idle may sleep
    assign SLEEP_VSS_EN =
        endian_sleep_register_q[tdec_pkg::END_SLP_VSS_BIT] && !run;
    assign SLEEP_VDD_EN =
        endian_sleep_register_q[tdec_pkg::END_SLP_VDD_BIT] && !run;
    assign MAP_STATE = map_state;
    assign RUN_STATUS = run;
    assign WAIT_CONFIG_FLAG = wait_ic;
endmodule : tdec_ctrl
`default_nettype wire

// [verif/tdec_ctrl_sva.sv]
// assertions for the execution control register bank
`timescale 1ns/100ps
`default_nettype none
module tdec_ctrl_sva #(
    parameter int DECODES = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HRESP,
    // decoder side
    input wire logic EXT_NATIVE,
    input wire logic INTER_NATIVE,
    input wire logic SLEEP_VSS_EN,
    input wire logic SLEEP_VDD_EN,
    input wire logic [3:0] MAP_STATE,
    input wire logic RUN_STATUS,
    input wire logic WAIT_CONFIG_FLAG
);
    logic wr_q;
    logic [7:0] ad_q;
    always_ff @(posedge CLK) begin
        wr_q <= RST_N && HSEL && HREADY && HTRANS[1] && HWRITE;
        ad_q <= HADDR[7:0];
    end
    wire wend = wr_q && ad_q == tdec_pkg::OFS_END;
    // 4'hF marks a cycle with no execution write
    wire wexe = wr_q && ad_q == tdec_pkg::OFS_EXEC;
    wire [3:0] code = wexe ? HWDATA[3:0] : 4'hF;
    // shadow of the endian/sleep register as written over the bus
    logic [5:0] end_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            end_q <= 6'h00;
        end else if (wend) begin
            end_q <= HWDATA[5:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    run_flag_a: assert property (RUN_STATUS == (MAP_STATE != 4'h0))
        else $error("run flag wrong");
    wait_idle_a: assert property (
        WAIT_CONFIG_FLAG |-> MAP_STATE == 4'h0)
        else $error("wait flag while active");
    ext_fmt_a: assert property (wend |=> EXT_NATIVE == $past(HWDATA[0]))
        else $error("extrinsic format bit wrong");
    inter_fmt_a: assert property (
        wend |=> INTER_NATIVE == $past(HWDATA[1]))
        else $error("interleaver format bit wrong");
    vss_sleep_a: assert property (SLEEP_VSS_EN |-> !RUN_STATUS)
        else $error("vss sleep while running");
    vdd_sleep_a: assert property (SLEEP_VDD_EN |-> !RUN_STATUS)
        else $error("vdd sleep while running");
    start_run_a: assert property (code == 4'h1 && WAIT_CONFIG_FLAG
        |-> ##[1:8] MAP_STATE == tdec_pkg::MAP_FIRST) else $error("no start");
    debug_hold_a: assert property (code == 4'h4 && WAIT_CONFIG_FLAG
        |=> (MAP_STATE == 4'h0) [*8]) else $error("debug hold lost");
    step_hold_a: assert property (code == 4'h5 && MAP_STATE == 4'h0
        && !WAIT_CONFIG_FLAG |-> ##[2:14] (MAP_STATE == 4'h6) [*3])
        else $error("step did not hold in state 6");
    complete_a: assert property (code == 4'h6 && MAP_STATE == 4'h6
        |-> ##[1:40] WAIT_CONFIG_FLAG) else $error("complete did not end");
    soft_reset_a: assert property (code == 4'h2
        |-> ##[1:3] (MAP_STATE == 4'h0 && WAIT_CONFIG_FLAG))
        else $error("soft reset left sequencer busy");
    vss_idle_a: assert property (
        !RUN_STATUS |-> SLEEP_VSS_EN == end_q[tdec_pkg::END_SLP_VSS_BIT])
        else $error("vss sleep enable wrong while idle");
    vdd_idle_a: assert property (
        !RUN_STATUS |-> SLEEP_VDD_EN == end_q[tdec_pkg::END_SLP_VDD_BIT])
        else $error("vdd sleep enable wrong while idle");
    end_keep_a: assert property (
        EXT_NATIVE == end_q[tdec_pkg::END_EXT_BIT]
        && INTER_NATIVE == end_q[tdec_pkg::END_INTER_BIT])
        else $error("format bits lost");
    resp_okay_a: assert property (!HRESP)
        else $error("error response on the bus");
endmodule : tdec_ctrl_sva
bind tdec_ctrl tdec_ctrl_sva #(.DECODES(DECODES)) tdec_ctrl_sva_i (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRESP(HRESP),
    .EXT_NATIVE(EXT_NATIVE), .INTER_NATIVE(INTER_NATIVE),
    .SLEEP_VSS_EN(SLEEP_VSS_EN), .SLEEP_VDD_EN(SLEEP_VDD_EN),
    .MAP_STATE(MAP_STATE), .RUN_STATUS(RUN_STATUS),
    .WAIT_CONFIG_FLAG(WAIT_CONFIG_FLAG));
`default_nettype wire

// [verif/tdec_host.sv]
// host bus master model driving the register bank
`timescale 1ns/100ps
`default_nettype none
module tdec_host (
    // clock
    input wire logic clk,
    // bus
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // result
    output logic [31:0] rdata,
    output logic hung
);
    event rd_ev;
    initial begin
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rdata = 32'h0;
        hung = 1'b0;
    end
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!hready && n < 64);
        if (!hready) hung = 1'b1;
    endtask : wait_rdy
    // on reads hwdata toggles so nothing stale passes for valid data
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        wait_rdy();
        if (!w) begin
            rdata = hrdata;
            -> rd_ev;
        end
    endtask : xfer
endmodule : tdec_host
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench of the execution control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %h seen %h", n, e, v); end end
module tb_top;
    logic clk, rst_n, hwrite, hready;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, seed, e_w, m_w;
    logic [31:0] exp_q[$], msk_q[$], icv[16];
    int error_cnt = 0;
    int check_count = 0;
    localparam logic [31:0] A_EX = 32'(tdec_pkg::OFS_EXEC);
    localparam logic [31:0] A_EN = 32'(tdec_pkg::OFS_END);
    localparam logic [31:0] A_ST = 32'(tdec_pkg::OFS_STAT);
    localparam logic [31:0] A_IC = 32'(tdec_pkg::OFS_IC0);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    tdec_host host_i (.clk(clk), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .rdata(), .hung());
    // short decode count keeps the run brief
    tdec_ctrl #(.DECODES(2)) tdec_ctrl_i (.CLK(clk), .RST_N(rst_n),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(), .EXT_NATIVE(), .INTER_NATIVE(),
        .SLEEP_VSS_EN(), .SLEEP_VDD_EN(), .MAP_STATE(), .RUN_STATUS(),
        .WAIT_CONFIG_FLAG());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task conclude;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        host_i.xfer(1'b0, a, 32'h0);
    endtask : rd
    task wr(input logic [31:0] a, input logic [31:0] d);
        host_i.xfer(1'b1, a, d);
    endtask : wr
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task poll(input int b, input logic v);
        for (int n = 0; n < 40; n++) begin
            // a normal run never shows the debug bit
            rd(A_ST, 32'h0, 32'h4);
            if (host_i.rdata[b] === v) return;
        end
        error_cnt++;
        conclude();
    endtask : poll
    always @(host_i.rd_ev) begin
        e_w = exp_q.pop_front();
        m_w = msk_q.pop_front();
        `CHK("read data", e_w, host_i.rdata & m_w)
    end
    always @(posedge clk) if (host_i.hung) begin
        error_cnt++;
        conclude();
    end
    initial begin
        wt(20000);
        error_cnt++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        seed = 32'hC83D;
        wt(3);
        rst_n <= 1'b1;
        rd(A_EN, 32'h0, 32'hFFFFFFFF);
        rd(A_ST, 32'h2, 32'hF7);
        rd(32'h20, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(A_EN, seed);
            rd(A_EN, seed, 32'h33);
        end
        wr(A_EN, 32'h33);
        rd(A_EN, 32'h33, 32'hFFFFFFFF);
        wr(A_EN, 32'h0);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            icv[i] = seed;
            wr(A_IC + 32'(4 * i), seed);
        end
        for (int i = 0; i < 16; i++) rd(A_IC + 32'(4 * i), icv[i], '1);
        wr(A_EX, 32'h1);
        rd(A_EX, 32'h1, 32'hF);
        poll(0, 1'b1);
        poll(1, 1'b1);
        wr(A_EX, 32'h4);
        wt(10);
        rd(A_ST, 32'h4, 32'hF7);
        wr(A_EX, 32'h5);
        wt(14);
        rd(A_ST, 32'h61, 32'hF3);
        wr(A_EX, 32'h6);
        wt(14);
        rd(A_ST, 32'h2, 32'hF7);
        wr(A_EX, 32'h5);
        wt(12);
        rd(A_ST, 32'h2, 32'hF3);
        wr(A_EN, 32'h33);
        wr(A_EX, 32'h4);
        wt(10);
        // step with sleep enabled, then soft reset out of the hold
        wr(A_EX, 32'h5);
        wt(10);
        wr(A_EX, 32'h2);
        wt(4);
        rd(A_ST, 32'h2, 32'hF7);
        rd(A_IC, 32'h0, 32'hFFFFFFFF);
        rd(A_EX, 32'h2, 32'hF);
        rd(A_EN, 32'h33, 32'hFFFFFFFF);
        wt(2);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
